/* core/pwmg_gen.sv */
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_consts.svh"

// Behaviour
// - dead-time field: pos, neg-comp, off, reserved
// - time-base select picks secondary or primary
// - center-aligned bit selects up-down counting
// - center-aligned ignored unless independent base
// - limit event resets local base if enabled, with independent base on and limit mode off
// - immediate update loads values at once
// - otherwise values load at period boundary
// - center-aligned drops three low bits
// - independent mode: primary duty drives high
// - other modes: primary duty drives both
// - secondary duty drives low when independent
// - base off, modes 0-2: phase both
// - base off, mode 3: phase both
// - base on, modes 0-2: local period both
// - base on, mode 3: local period both
module pwmg_gen #(
    parameter int DT_WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prim_tick,
    input wire logic prim_sync,
    input wire logic [15:0] prim_period,
    input wire logic sec_tick,
    input wire logic sec_sync,
    input wire logic [15:0] sec_period,
    input wire logic limit_event,
    output logic high_side_output,
    output logic low_side_output,
    output logic [1:0] dt_active_mode
);
    import pwmg_pkg::*;

    initial begin
        if (DT_WIDTH < 1 || DT_WIDTH > 14) $error("DT_WIDTH out of range");
    end

    // ****************************************
    // register file
    // ****************************************
    logic [15:0] ctrl_q;
    logic [15:0] mode_q;
    logic [15:0] pduty_q;
    logic [15:0] sduty_q;
    logic [15:0] phase_q;
    logic [DT_WIDTH-1:0] dt_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic dir_q;
    logic dir_d;
    logic bnd_q;
    logic hi_q;
    logic lo_q;
    logic [1:0] dtm_q;
    logic [DT_WIDTH-1:0] dtc_q;

    wire logic wr_en;
    wire logic rd_en;
    wire logic addr_ok;
    wire logic [31:0] rd_mux;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr == `PWMG_ADDR_CTRL) | (paddr == `PWMG_ADDR_PDUTY) |
        (paddr == `PWMG_ADDR_SDUTY) | (paddr == `PWMG_ADDR_PHASE) |
        (paddr == `PWMG_ADDR_MODE) | (paddr == `PWMG_ADDR_STAT);
    assign rd_mux = (paddr == `PWMG_ADDR_CTRL) ? {16'h0000, ctrl_q} :
        (paddr == `PWMG_ADDR_PDUTY) ? {16'h0000, pduty_q} :
        (paddr == `PWMG_ADDR_SDUTY) ? {16'h0000, sduty_q} :
        (paddr == `PWMG_ADDR_PHASE) ? {16'h0000, phase_q} :
        (paddr == `PWMG_ADDR_MODE) ? {16'h0000, mode_q} :
        (paddr == `PWMG_ADDR_STAT) ? {16'h0000, cnt_q} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `PWMG_RST16;
            mode_q <= `PWMG_RST16;
            pduty_q <= `PWMG_RST16;
            sduty_q <= `PWMG_RST16;
            phase_q <= `PWMG_RST16;
        end else if (wr_en) begin
            if (paddr == `PWMG_ADDR_CTRL) ctrl_q <= pwdata[15:0] & `PWMG_CTRL_MASK;
            if (paddr == `PWMG_ADDR_MODE) mode_q <= pwdata[15:0] & `PWMG_MODE_MASK;
            if (paddr == `PWMG_ADDR_PDUTY) pduty_q <= pwdata[15:0];
            if (paddr == `PWMG_ADDR_SDUTY) sduty_q <= pwdata[15:0];
            if (paddr == `PWMG_ADDR_PHASE) phase_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ****************************************
    // mode decode
    // ****************************************
    wire logic independent_base_en;
    wire logic cam_eff;
    wire logic xpr_eff;
    wire logic enabled;
    wire pwmg_om_t omode;
    wire pwmg_dt_t dtmode;
    assign independent_base_en = ctrl_q[`PWMG_B_ITB];
    assign cam_eff = ctrl_q[`PWMG_B_CAM] & independent_base_en;
    // limit reset needs independent base and limit mode off
    assign xpr_eff = ctrl_q[`PWMG_B_XPR] & independent_base_en & ~mode_q[`PWMG_B_CURRENT_LIMIT_MODE];
    assign enabled = mode_q[`PWMG_B_EN];
    assign omode = pwmg_om_t'(mode_q[`PWMG_B_OM_HI:`PWMG_B_OM_LO]);
    assign dtmode = pwmg_dt_t'(ctrl_q[`PWMG_B_DTC_HI:`PWMG_B_DTC_LO]);

    // ****************************************
    // time base selection
    // ****************************************
    wire logic tick;
    wire logic msync;
    wire logic [15:0] mperiod;
    assign tick = ctrl_q[`PWMG_B_MASTER_BASE_SELECT] ? sec_tick : prim_tick;
    assign msync = ctrl_q[`PWMG_B_MASTER_BASE_SELECT] ? sec_sync : prim_sync;
    assign mperiod = ctrl_q[`PWMG_B_MASTER_BASE_SELECT] ? sec_period : prim_period;

    // ****************************************
    // active values
    // ****************************************
    pwmg_act_if act_bus ();
    wire logic [15:0] period;
    wire logic [15:0] eff_pd;
    wire logic [15:0] eff_sd;
    wire logic [15:0] eff_ph;

    function automatic logic [15:0] ca_trim(input logic [15:0] v, input logic ca);
        ca_trim = ca ? (v & `PWMG_CA_MASK) : v;
    endfunction

    pwmg_shadow u_shadow (
        .pclk(pclk),
        .presetn(presetn),
        .pduty_buf(pduty_q),
        .sduty_buf(sduty_q),
        .phase_buf(phase_q),
        .immediate(ctrl_q[`PWMG_B_IUE]),
        .boundary(bnd_q),
        .act(act_bus.src)
    );

    assign eff_pd = ca_trim(act_bus.pduty, cam_eff);
    assign eff_sd = ca_trim(act_bus.sduty, cam_eff);
    assign eff_ph = ca_trim(act_bus.phase, cam_eff);
    // local period for itb, master period otherwise
    assign period = independent_base_en ? act_bus.phase : mperiod;

    // ****************************************
    // local counter
    // ****************************************
    wire logic at_top;
    wire logic at_bot;
    wire logic restart;
    assign at_top = cnt_q >= period;
    assign at_bot = cnt_q == `PWMG_RST16;
    // non-itb: realign to master sync at phase offset
    assign restart = (xpr_eff & limit_event) | (~independent_base_en & msync);

    always_comb begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        if (!enabled) begin
            cnt_d = `PWMG_RST16;
            dir_d = PWMG_CNT_UP;
        end else if (restart) begin
            cnt_d = independent_base_en ? `PWMG_RST16 : eff_ph;
            dir_d = PWMG_CNT_UP;
        end else if (tick) begin
            if (cam_eff) begin
                if (dir_q == PWMG_CNT_UP && at_top) begin
                    dir_d = PWMG_CNT_DN;
                    cnt_d = cnt_q - `PWMG_ONE16;
                end else if (dir_q == PWMG_CNT_DN && at_bot) begin
                    dir_d = PWMG_CNT_UP;
                    cnt_d = cnt_q + `PWMG_ONE16;
                end else begin
                    cnt_d = (dir_q == PWMG_CNT_UP) ? cnt_q + `PWMG_ONE16 : cnt_q - `PWMG_ONE16;
                end
            end else begin
                dir_d = PWMG_CNT_UP;
                cnt_d = at_top ? `PWMG_RST16 : cnt_q + `PWMG_ONE16;
            end
        end
    end

    wire logic bnd_d;
    assign bnd_d = enabled & tick & ((cam_eff & dir_q == PWMG_CNT_DN & at_bot) | (~cam_eff & at_top));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `PWMG_RST16;
            dir_q <= PWMG_CNT_UP;
            bnd_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            bnd_q <= bnd_d | (enabled & restart);
        end
    end

    // ****************************************
    // output generation
    // ****************************************
    wire logic indep;
    wire logic raw_h;
    wire logic raw_l;
    wire logic dt_on;
    wire logic hi_d;
    wire logic lo_d;
    assign indep = omode == PWMG_OM_IND;
    assign raw_h = enabled & (cnt_q < eff_pd);
    // low follows secondary duty only when independent
    assign raw_l = indep ? (enabled & (cnt_q < eff_sd)) :
        (omode == PWMG_OM_COMP) ? (enabled & ~raw_h) : raw_h;
    // dead time: pos all modes, neg comp only, off, reserved off
    assign dt_on = enabled & ((dtmode == PWMG_DT_POS) |
        ((dtmode == PWMG_DT_NEG) & (omode == PWMG_OM_COMP)));
    assign hi_d = raw_h & ~(dt_on & (dtc_q != '0) & ~hi_q);
    assign lo_d = raw_l & ~(dt_on & (dtc_q != '0) & ~lo_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            dtc_q <= '0;
            dtm_q <= 2'b00;
            dt_q <= '0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
            dt_q <= {DT_WIDTH{1'b1}};
            dtm_q <= dt_on ? ctrl_q[`PWMG_B_DTC_HI:`PWMG_B_DTC_LO] : 2'b10;
            if ((raw_h != hi_q) | (raw_l != lo_q)) dtc_q <= (dtc_q == '0) ? dt_q : dtc_q - 1'b1;
            else dtc_q <= '0;
        end
    end

    assign high_side_output = hi_q;
    assign low_side_output = lo_q;
    assign dt_active_mode = dtm_q;

    a_cam_gated: assert property (@(posedge pclk) disable iff (!presetn)
        (!independent_base_en && enabled && tick && !restart && at_top) |=> cnt_q == 16'h0000)
        else $error("center mode active without independent base");
    a_edge_high: assert property (@(posedge pclk) disable iff (!presetn)
        (enabled && !cam_eff && cnt_q >= eff_pd) |=> !high_side_output)
        else $error("high stays on past duty");
    a_xpr_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (enabled && xpr_eff && limit_event) |=> cnt_q == 16'h0000)
        else $error("limit event did not reset base");
    a_comp_low: assert property (@(posedge pclk) disable iff (!presetn)
        (omode == PWMG_OM_COMP && dtmode == PWMG_DT_OFF) |=> !(high_side_output && low_side_output))
        else $error("complementary outputs overlap");
    a_ca_trim: assert property (@(posedge pclk) disable iff (!presetn)
        cam_eff |-> eff_pd[2:0] == 3'b000)
        else $error("low duty bits used in center mode");
    a_dt_off: assert property (@(posedge pclk) disable iff (!presetn)
        (dtmode == PWMG_DT_NEG && omode != PWMG_OM_COMP) |=> dt_active_mode == 2'b10)
        else $error("negative dead time outside comp mode");
    c_center: cover property (@(posedge pclk) cam_eff && dir_q == PWMG_CNT_DN);
    c_indep: cover property (@(posedge pclk) indep && high_side_output && low_side_output);
    c_bnd: cover property (@(posedge pclk) bnd_q && !ctrl_q[`PWMG_B_IUE]);
endmodule
`default_nettype wire

/* core/pwmg_shadow.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_consts.svh"

// active copies of the buffered values
module pwmg_shadow (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] pduty_buf,
    input wire logic [15:0] sduty_buf,
    input wire logic [15:0] phase_buf,
    input wire logic immediate,
    input wire logic boundary,
    pwmg_act_if.src act
);
    import pwmg_pkg::*;
    wire logic take;
    assign take = immediate | boundary;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act.pduty <= `PWMG_RST16;
            act.sduty <= `PWMG_RST16;
            act.phase <= `PWMG_RST16;
            act.load <= 1'b0;
        end else begin
            act.load <= take;
            if (take) begin
                act.pduty <= pduty_buf;
                act.sduty <= sduty_buf;
                act.phase <= phase_buf;
            end
        end
    end

    a_sync_update: assert property (@(posedge pclk) disable iff (!presetn)
        (!immediate && !boundary) |=> $stable(act.pduty))
        else $error("active duty changed off boundary");
    a_imm_update: assert property (@(posedge pclk) disable iff (!presetn)
        immediate |=> act.pduty == $past(pduty_buf))
        else $error("immediate update not applied");
endmodule
`default_nettype wire

/* inc/pwmg_act_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pwmg_act_if;
    logic [15:0] pduty;
    logic [15:0] sduty;
    logic [15:0] phase;
    logic load;
    modport src (output pduty, output sduty, output phase, output load);
    modport dst (input pduty, input sduty, input phase, input load);
endinterface
`default_nettype wire

/* inc/pwmg_consts.svh */
`ifndef PWMG_CONSTS_SVH
`define PWMG_CONSTS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define PWMG_ADDR_CTRL 12'h000
`define PWMG_ADDR_PDUTY 12'h004
`define PWMG_ADDR_SDUTY 12'h008
`define PWMG_ADDR_PHASE 12'h00C
`define PWMG_ADDR_MODE 12'h010
`define PWMG_ADDR_STAT 12'h014

// ****************************************
// control field positions
// ****************************************
`define PWMG_B_IUE 0
`define PWMG_B_XPR 1
`define PWMG_B_CAM 2
`define PWMG_B_MASTER_BASE_SELECT 3
`define PWMG_B_DTC_LO 6
`define PWMG_B_DTC_HI 7
`define PWMG_B_ITB 9
`define PWMG_CTRL_MASK 16'h02CF

// ****************************************
// mode register fields
// ****************************************
`define PWMG_B_OM_LO 0
`define PWMG_B_OM_HI 1
`define PWMG_B_CURRENT_LIMIT_MODE 2
`define PWMG_B_EN 3
`define PWMG_MODE_MASK 16'h000F

// ****************************************
// reset values and constants
// ****************************************
`define PWMG_RST16 16'h0000
`define PWMG_CA_MASK 16'hFFF8
`define PWMG_ONE16 16'h0001

`endif

/* inc/pwmg_pkg.sv */
package pwmg_pkg;
    typedef enum logic [1:0] {
        PWMG_DT_POS = 2'b00,
        PWMG_DT_NEG = 2'b01,
        PWMG_DT_OFF = 2'b10,
        PWMG_DT_RSV = 2'b11
    } pwmg_dt_t;

    typedef enum logic [1:0] {
        PWMG_OM_COMP = 2'b00,
        PWMG_OM_RED = 2'b01,
        PWMG_OM_PP = 2'b10,
        PWMG_OM_IND = 2'b11
    } pwmg_om_t;

    typedef enum logic [0:0] {
        PWMG_CNT_UP = 1'b0,
        PWMG_CNT_DN = 1'b1
    } pwmg_dir_t;
endpackage

/* tb/pwmg_gate_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************
// gate driver pair: records pulse widths seen on both outputs
// ****************
module pwmg_gate_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hi,
    input wire logic lo
);
    int cnt_h, cnt_l, last_h, last_l, n_h, n_l;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_h <= 0;
            cnt_l <= 0;
            n_h <= 0;
            n_l <= 0;
        end else begin
            cnt_h <= hi ? cnt_h + 1 : 0;
            cnt_l <= lo ? cnt_l + 1 : 0;
            if (!hi && cnt_h != 0) begin
                last_h <= cnt_h;
                n_h <= n_h + 1;
            end
            if (!lo && cnt_l != 0) begin
                last_l <= cnt_l;
                n_l <= n_l + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/pwmg_gen_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pwmg_consts.svh"

module pwmg_gen_tb;
    import pwmg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, hi, lo;
    logic prim_tick = 1, sec_tick = 1, limit_event = 0;
    logic [1:0] dtm;
    logic [31:0] rd, c1;
    logic er;
    int errors = 0, num_checks = 0, cyc = 0;

    pwmg_gen dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prim_tick(prim_tick), .prim_sync(1'b0), .prim_period(16'h0100), .sec_tick(sec_tick),
        .sec_sync(1'b0), .sec_period(16'h0100), .limit_event(limit_event), .high_side_output(hi),
        .low_side_output(lo), .dt_active_mode(dtm));
    pwmg_gate_model gm (.pclk(pclk), .presetn(presetn), .hi(hi), .lo(lo));

    always #50 pclk = ~pclk;

    // ****************
    // helpers
    // ****************
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // hold the request until pready is seen at a rising edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wait_run(input logic low);
        int n0;
        n0 = low ? gm.n_l : gm.n_h;
        for (int i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if ((low ? gm.n_l : gm.n_h) > n0) break;
        end
    endtask

    task automatic wait_rise();
        for (int i = 0; i < 3000; i++) begin
            @(posedge pclk);
            if (hi === 1'b1) break;
        end
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        for (int a = 0; a < 5; a++) begin
            apb(0, 12'(a * 4), 0);
            chk(rd === 32'h0000_0000 && er === 1'b0, "reset value");
        end
        apb(1, `PWMG_ADDR_PDUTY, 32'h0000_A5A5);
        apb(0, `PWMG_ADDR_PDUTY, 0);
        chk(rd === 32'h0000_A5A5, "duty readback");
        apb(1, `PWMG_ADDR_CTRL, 32'h0000_FFFF);
        apb(0, `PWMG_ADDR_CTRL, 0);
        chk(rd === 32'h0000_02CF, "control mask");
        apb(0, 12'h020, 0);
        chk(er === 1'b1 && rd === 32'h0000_0000, "unmapped");
    endtask

    task automatic t_dt(input logic [1:0] om, input logic [1:0] code, input logic [1:0] exp);
        apb(1, `PWMG_ADDR_MODE, {28'h0, 2'b10, om});
        apb(1, `PWMG_ADDR_CTRL, {24'h2, code, 6'h01});
        repeat (20) @(posedge pclk);
        chk(dtm === exp, "dead-time mode");
    endtask

    task automatic t_indep();
        apb(1, `PWMG_ADDR_CTRL, 32'h0000_0281);
        apb(1, `PWMG_ADDR_PHASE, 32'h0000_0040);
        apb(1, `PWMG_ADDR_PDUTY, 32'h0000_0010);
        apb(1, `PWMG_ADDR_SDUTY, 32'h0000_0020);
        apb(1, `PWMG_ADDR_MODE, 32'h0000_000B);
        wait_run(0);
        wait_run(0);
        wait_run(1);
        wait_run(1);
        chk(gm.last_l - gm.last_h == 16, "low width follows secondary duty");
    endtask

    task automatic t_update();
        int ref0;
        apb(1, `PWMG_ADDR_MODE, 32'h0000_0008);
        apb(1, `PWMG_ADDR_CTRL, 32'h0000_0280);
        wait_run(0);
        wait_run(0);
        ref0 = gm.last_h;
        wait_rise();
        apb(1, `PWMG_ADDR_PDUTY, 32'h0000_0030);
        wait_run(0);
        chk(gm.last_h == ref0, "deferred duty applied early");
        wait_run(0);
        chk(gm.last_h == ref0 + 32, "deferred duty width");
        apb(1, `PWMG_ADDR_CTRL, 32'h0000_0281);
        wait_run(0);
        wait_rise();
        apb(1, `PWMG_ADDR_PDUTY, 32'h0000_0010);
        wait_run(0);
        chk(gm.last_h == ref0, "immediate duty late");
    endtask

    task automatic t_base(input logic sel, input logic [31:0] ctrl);
        prim_tick <= !sel;
        sec_tick <= sel;
        apb(1, `PWMG_ADDR_CTRL, ctrl);
        apb(0, `PWMG_ADDR_STAT, 0);
        c1 = rd;
        repeat (10) @(posedge pclk);
        apb(0, `PWMG_ADDR_STAT, 0);
        chk((rd !== c1) === (sel == ctrl[3]), "base select");
    endtask

    task automatic t_ext_period_reset_en(input logic [31:0] ctrl);
        apb(1, `PWMG_ADDR_CTRL, ctrl);
        repeat (40) @(posedge pclk);
        limit_event <= 1;
        @(posedge pclk);
        limit_event <= 0;
        apb(0, `PWMG_ADDR_STAT, 0);
        chk((rd[15:0] <= 16'h0008) === ctrl[1], "limit reset");
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_regs();
        // mode bits are set together with enable, and later rewritten while enable stays set
        t_dt(2'b00, 2'b00, 2'b00);
        t_dt(2'b00, 2'b01, 2'b01);
        t_dt(2'b00, 2'b10, 2'b10);
        t_dt(2'b00, 2'b11, 2'b10);
        t_dt(2'b11, 2'b01, 2'b10);
        t_indep();
        t_update();
        t_base(1, 32'h0000_0080);
        t_base(1, 32'h0000_0088);
        t_base(0, 32'h0000_0080);
        // phase kept within the master period; no interrupt to clear here
        apb(1, `PWMG_ADDR_PHASE, 32'h0000_0100);
        // limit mode left clear, independent base set
        t_ext_period_reset_en(32'h0000_0282);
        t_ext_period_reset_en(32'h0000_0280);
        end_of_test();
    end
endmodule
`default_nettype wire
